// ==== bench/asr_checker.sv ====
// Concurrent checks on the serial result port pins
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_checker (
  input logic clk_i,
  input logic rst_i,
  input logic serial_parallel_select_i,
  input logic clock_source_select_i,
  input logic read_timing_or_chain_in_i,
  input logic chip_select_n_i,
  input logic read_n_i,
  input logic clock_invert_i,
  input logic serial_result_out_o,
  input logic serial_result_oe_o,
  input logic shift_clock_o,
  input logic shift_clock_oe_o,
  input logic word_frame_o,
  input logic word_frame_oe_o,
  input logic busy_o,
  input logic incomplete_read_flag_o
);
  // ****************************************************************
  // Helper counters: busy width and clock rises inside a frame
  // ****************************************************************
  logic [9:0] bcnt_q, bcnt_d;
  logic [4:0] rcnt_q, rcnt_d;
  logic       sclk_q;
  always_comb
  begin
    bcnt_d = busy_o ? bcnt_q + 10'h001 : 10'h000;
    rcnt_d = word_frame_o ? rcnt_q + {4'h0, shift_clock_o & !sclk_q} : 5'h00;
  end
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      bcnt_q <= 10'h000;
      rcnt_q <= 5'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      bcnt_q <= bcnt_d;
      rcnt_q <= rcnt_d;
      sclk_q <= shift_clock_o;
    end
  // ****************************************************************
  // Assertions; pins pass two synchroniser stages, hence the [*5]
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_release_a: assert property ((chip_select_n_i || read_n_i)[*5] |->
    !serial_result_oe_o && !word_frame_oe_o) else $error("oe while released");
  serial_off_a: assert property (!serial_parallel_select_i[*5] |->
    !serial_result_oe_o && !shift_clock_oe_o) else $error("serial port on");
  master_drive_a: assert property ((!clock_source_select_i &&
    serial_parallel_select_i && !chip_select_n_i && !read_n_i)[*5] |->
    shift_clock_oe_o && word_frame_oe_o) else $error("master not driving");
  slave_clk_a: assert property (clock_source_select_i[*5] |->
    !shift_clock_oe_o) else $error("slave drives clock");
  conv_len_a: assert property ($fell(busy_o) && clock_source_select_i |->
    bcnt_q == `ASR_CONV_CYCLES) else $error("conversion width wrong");
  master_busy_a: assert property ($fell(busy_o) &&
    !clock_source_select_i && !read_timing_or_chain_in_i &&
    serial_parallel_select_i |-> bcnt_q >= 10'h1DE)
    else $error("busy fell before word sent");
  frame_len_a: assert property ($fell(word_frame_o) && !clock_invert_i
    |-> rcnt_q == 5'h10) else $error("frame not sixteen clocks");
  data_stable_a: assert property ($changed(shift_clock_o) &&
    shift_clock_oe_o |-> $stable(serial_result_out_o))
    else $error("data moved on clock edge");
  invert_idle_a: assert property ((clock_invert_i && word_frame_o)[*5]
    |-> shift_clock_o) else $error("inverted clock not idle high");
  rderr_pulse_a: assert property (incomplete_read_flag_o |=>
    !incomplete_read_flag_o) else $error("flag longer than a pulse");
  cover property ($fell(word_frame_o));
  cover property ($rose(incomplete_read_flag_o));
  cover property ($fell(busy_o) && clock_source_select_i);
endmodule

bind asr_serial_port asr_checker u_chk (.*);

// ==== bench/asr_host_model.sv ====
// Host side model: slave clock source and master word receiver
`timescale 1ns/1ps
module asr_host_model (
  input  wire logic        sdo_i,
  input  wire logic        mclk_i,
  input  wire logic        frame_i,
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic [19:0]      word_o,
  output logic [15:0]      mword_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    word_o = 20'h00000;
    mword_o = 16'h0000;
  end
  // Master words taken on the rising clock, non-inverted only
  always @(posedge mclk_i)
    if (frame_i)
      mword_o <= {mword_o[14:0], sdo_i};
  task automatic select(input logic lvl);
    cs_n_o = lvl;
    rd_n_o = lvl;
  endtask
  // 80 ns host clock, runs only inside a burst; samples before each rise
  task automatic read_bits(input int n, input logic idle);
    if (sclk_o !== idle)
    begin
      // Settle the idle level while deselected, so no false edge counts
      sclk_o = idle;
      #40;
    end
    select(1'b0);
    #40;
    for (int i = 0; i < n; i++)
    begin
      sclk_o = 1'b0;
      #40;
      word_o = {word_o[18:0], sdo_i};
      sclk_o = 1'b1;
      #40;
    end
    sclk_o = idle;
    select(1'b1);
  endtask
endmodule

// ==== bench/test_adc_serial_result_port.sv ====
// Self-checking bench for the serial result port
`timescale 1ns/1ps
module test_adc_serial_result_port;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        spsel, cksel, rdc, cnv_n, pd, inv;
  logic [15:0] res;
  logic        sdo, sdo_oe, mclk, mclk_oe, frame, frame_oe, busy, rderr;
  logic        hclk, cs_n, rd_n;
  logic [19:0] word;
  logic [15:0] mword;
  wire         sclk_w = mclk_oe ? mclk : hclk;
  int          mismatches = 0;
  int          check_count = 0;
  int          flags = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (rderr === 1'b1)
      flags++;
  asr_serial_port dut (
    .clk_i(clk_i), .rst_i(rst_i), .serial_parallel_select_i(spsel),
    .clock_source_select_i(cksel), .read_timing_or_chain_in_i(rdc),
    .chip_select_n_i(cs_n), .read_n_i(rd_n), .conversion_start_n_i(cnv_n),
    .power_down_input_i(pd), .shift_clock_i(sclk_w), .clock_invert_i(inv),
    .conv_result_i(res), .serial_result_out_o(sdo),
    .serial_result_oe_o(sdo_oe), .shift_clock_o(mclk),
    .shift_clock_oe_o(mclk_oe), .word_frame_o(frame),
    .word_frame_oe_o(frame_oe), .busy_o(busy),
    .incomplete_read_flag_o(rderr));
  asr_host_model host (
    .sdo_i(sdo), .mclk_i(mclk), .frame_i(frame), .sclk_o(hclk),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .word_o(word), .mword_o(mword));
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 2000 && busy !== lvl; n++)
      tick(1);
    check({19'h0, busy}, {19'h0, lvl});
  endtask
  task automatic convert(input logic [15:0] r);
    res = r;
    cnv_n = 1'b0;
    tick(6);
    cnv_n = 1'b1;
    wait_busy(1'b1);
  endtask
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
  initial
  begin
    {spsel, cksel, rdc, cnv_n, pd, inv} = 6'h3C;
    res = 16'h0000;
    tick(20);
    rst_i = 1'b0;
    // Slave read after conversion, chain input held high, idle-high clock
    convert(16'hA5C3);
    wait_busy(1'b0);
    host.read_bits(20, 1'b1);
    check(word, {16'hA5C3, 4'hF});
    // Power-down mid conversion must not shorten it
    rdc = 1'b0;
    convert(16'h3C5A);
    pd = 1'b1;
    wait_busy(1'b0);
    pd = 1'b0;
    // Read straddling into the next conversion gives the previous word
    host.read_bits(12, 1'b0);
    convert(16'hC3A5);
    host.read_bits(4, 1'b0);
    check({4'h0, word[15:0]}, 20'h03C5A);
    wait_busy(1'b0);
    tick(4);
    check(20'(flags), 20'h00000);
    // Partial read then conversion end raises the flag once
    convert(16'h1234);
    host.read_bits(8, 1'b0);
    wait_busy(1'b0);
    tick(4);
    check(20'(flags), 20'h00001);
    // Master, read during conversion sends the previous result
    cksel = 1'b0;
    rdc = 1'b1;
    host.select(1'b0);
    convert(16'h8001);
    wait_busy(1'b0);
    tick(10);
    check({4'h0, mword}, 20'h01234);
    // Master, read after conversion: busy spans the word
    rdc = 1'b0;
    convert(16'h7FFE);
    wait_busy(1'b0);
    check({4'h0, mword}, 20'h07FFE);
    host.select(1'b1);
    tick(6);
    check({17'h0, sdo_oe, mclk_oe, frame_oe}, 20'h00000);
    spsel = 1'b0;
    host.select(1'b0);
    tick(6);
    check({17'h0, sdo_oe, mclk_oe, frame_oe}, 20'h00000);
    spsel = 1'b1;
    tick(6);
    check({17'h0, sdo_oe, mclk_oe, frame_oe}, 20'h00007);
    inv = 1'b1;
    tick(8);
    check({18'h0, mclk, frame}, 20'h00003);
    convert(16'h5AA5);
    wait_busy(1'b0);
    close_out();
  end
endmodule

// ==== common/asr_defs.svh ====
// Constants of the serial result port: widths, reset values, timing counts
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ****************************************************************
// Word and counter widths
// ****************************************************************
`define ASR_WORD_BITS      16
`define ASR_BIT_CNT_W      6
`define ASR_BIT_CNT_MAX    6'h3F
`define ASR_CONV_CNT_W     12

// ****************************************************************
// Reset values
// ****************************************************************
// Field order: spsel cksel rdc cs_n rd_n cnv_n pd sclk inv
`define ASR_PIN_IN_RST     9'h038
`define ASR_PIN_OUT_RST    8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ASR_CLK_PERIOD_PS  4000
`define ASR_CONV_TIME_NS   1400
`define ASR_CONV_CYCLES    \
  ((`ASR_CONV_TIME_NS * 1000 + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS)
`define ASR_MCLK_PERIOD_NS 32
`define ASR_MCLK_HALF      \
  ((`ASR_MCLK_PERIOD_NS * 1000) / (2 * `ASR_CLK_PERIOD_PS))
`define ASR_MDIV_W         4

`endif

// ==== common/asr_pkg.sv ====
// Types shared by the serial result port
package asr_pkg;

  // ****************************************************************
  // Conversion sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_POST
  } asr_state_t;

  // ****************************************************************
  // Pins from outside the clock domain
  // ****************************************************************
  typedef struct packed {
    logic spsel;
    logic cksel;
    logic rdc;
    logic cs_n;
    logic rd_n;
    logic cnv_n;
    logic pd;
    logic sclk;
    logic inv;
  } asr_pin_in_t;

  // ****************************************************************
  // Registered interface outputs
  // ****************************************************************
  typedef struct packed {
    logic sdo;
    logic sdo_oe;
    logic sclk;
    logic sclk_oe;
    logic sync;
    logic sync_oe;
    logic busy;
    logic rderr;
  } asr_pin_out_t;

endpackage

// ==== hdl/asr_serial_port.sv ====
// Serial result port of a 16-bit sampling converter
`timescale 1ns/1ps
`include "asr_defs.svh"

// Contract
// - Serial port active while serial select high
// - Sixteen bits, MSB first, one per pulse
// - Data stable around the sampling clock edge
// - Clock source low: device drives shift clock
// - Master drives word-valid frame during data
// - Master clock and frame polarity invertible
// - Master read timing: after or during conversion
// - Master read-after: busy holds through sixteen bits
// - Clock source high: host supplies shift clock
// - Slave shifts only with select and read low
// - Slave accepts continuous or idling host clock
// - Slave read-after: read new result after busy
// - Slave read-after host clock up to 40 MHz
// - Chain input only in slave read-after mode
// - Chain bit latched on opposite clock edge
// - Slave read-during: previous result during conversion
// - Unfinished read at conversion end pulses flag
// - Read may straddle into next conversion
// - Select or read high: outputs released
// - Started conversion always runs to completion
module asr_serial_port (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          serial_parallel_select_i,
  input  wire logic          clock_source_select_i,
  input  wire logic          read_timing_or_chain_in_i,
  input  wire logic          chip_select_n_i,
  input  wire logic          read_n_i,
  input  wire logic          conversion_start_n_i,
  input  wire logic          power_down_input_i,
  input  wire logic          shift_clock_i,
  input  wire logic          clock_invert_i,
  input  wire logic [15:0]   conv_result_i,
  output logic               serial_result_out_o,
  output logic               serial_result_oe_o,
  output logic               shift_clock_o,
  output logic               shift_clock_oe_o,
  output logic               word_frame_o,
  output logic               word_frame_oe_o,
  output logic               busy_o,
  output logic               incomplete_read_flag_o
);
  import asr_pkg::*;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [`ASR_CONV_CNT_W-1:0] CONV_LAST =
    `ASR_CONV_CNT_W'(`ASR_CONV_CYCLES - 1);
  localparam logic [`ASR_MDIV_W-1:0] MDIV_LAST =
    `ASR_MDIV_W'(`ASR_MCLK_HALF - 1);
  localparam logic [`ASR_BIT_CNT_W-1:0] WORD_LAST =
    `ASR_BIT_CNT_W'(`ASR_WORD_BITS - 1);
  localparam logic [`ASR_BIT_CNT_W-1:0] WORD_BITS =
    `ASR_BIT_CNT_W'(`ASR_WORD_BITS);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Saturating bit counter, so a long daisy chain never wraps
  function automatic logic [`ASR_BIT_CNT_W-1:0] sat_inc(
    input logic [`ASR_BIT_CNT_W-1:0] v
  );
    sat_inc = (v == `ASR_BIT_CNT_MAX) ? v : v + 1'b1;
  endfunction

  // A read counts as started and unfinished between 1 and 15 bits
  function automatic logic partial_read(
    input logic [`ASR_BIT_CNT_W-1:0] v
  );
    partial_read = (v != '0) && (v < WORD_BITS);
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  asr_pin_in_t sync1_q;
  asr_pin_in_t sync1_d;
  asr_pin_in_t sync2_q;

  always_comb
  begin
    sync1_d.spsel = serial_parallel_select_i;
    sync1_d.cksel = clock_source_select_i;
    sync1_d.rdc   = read_timing_or_chain_in_i;
    sync1_d.cs_n  = chip_select_n_i;
    sync1_d.rd_n  = read_n_i;
    sync1_d.cnv_n = conversion_start_n_i;
    sync1_d.pd    = power_down_input_i;
    sync1_d.sclk  = shift_clock_i;
    sync1_d.inv   = clock_invert_i;
  end

  // The first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= asr_pin_in_t'(`ASR_PIN_IN_RST);
      sync2_q <= asr_pin_in_t'(`ASR_PIN_IN_RST);
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic serial_en;
  logic master;
  logic selected;
  logic rdc_mode;
  logic slave_rise;
  logic slave_fall;
  logic sclk_prev_q;

  always_comb
  begin
    serial_en  = sync2_q.spsel;
    master     = !sync2_q.cksel;
    selected   = !(sync2_q.cs_n | sync2_q.rd_n);
    rdc_mode   = sync2_q.rdc;
    // Host clock edges count only while the port is selected
    slave_rise = serial_en && !master && selected &&
                 sync2_q.sclk && !sclk_prev_q;
    slave_fall = serial_en && !master && selected &&
                 !sync2_q.sclk && sclk_prev_q;
  end

  // ****************************************************************
  // Sequencer and shifter state
  // ****************************************************************
  asr_state_t                   st_q;
  asr_state_t                   st_d;
  logic [`ASR_CONV_CNT_W-1:0]   conv_cnt_q;
  logic [`ASR_CONV_CNT_W-1:0]   conv_cnt_d;
  logic [15:0]                  result_q;
  logic [15:0]                  result_d;
  logic [15:0]                  sh_q;
  logic [15:0]                  sh_d;
  logic [`ASR_BIT_CNT_W-1:0]    bit_cnt_q;
  logic [`ASR_BIT_CNT_W-1:0]    bit_cnt_d;
  logic                         chain_q;
  logic                         chain_d;
  logic                         mrun_q;
  logic                         mrun_d;
  logic                         mclk_q;
  logic                         mclk_d;
  logic [`ASR_MDIV_W-1:0]       mdiv_q;
  logic [`ASR_MDIV_W-1:0]       mdiv_d;
  logic                         rderr_d;
  logic                         conv_done;
  logic                         conv_start;

  always_comb
  begin
    st_d       = st_q;
    conv_cnt_d = conv_cnt_q;
    result_d   = result_q;
    sh_d       = sh_q;
    bit_cnt_d  = bit_cnt_q;
    chain_d    = chain_q;
    mrun_d     = mrun_q;
    mclk_d     = mclk_q;
    mdiv_d     = mdiv_q;
    rderr_d    = 1'b0;
    conv_done  = (st_q == ST_CONV) && (conv_cnt_q == CONV_LAST);
    // Power-down only blocks a new start, never a running one
    conv_start = (st_q == ST_IDLE) && !sync2_q.cnv_n && !sync2_q.pd;

    // Master clock engine: data moves on the fall, host samples rise
    if (mrun_q)
    begin
      if (mdiv_q == MDIV_LAST)
      begin
        mdiv_d = '0;
        if (!mclk_q)
        begin
          mclk_d = 1'b1;
        end
        else
        begin
          mclk_d    = 1'b0;
          sh_d      = {sh_q[14:0], 1'b0};
          bit_cnt_d = sat_inc(bit_cnt_q);
          if (bit_cnt_q == WORD_LAST)
          begin
            mrun_d = 1'b0;
          end
        end
      end
      else
      begin
        mdiv_d = mdiv_q + 1'b1;
      end
    end

    // Slave shifter: advance on rise, chain bit caught on fall
    if (slave_rise)
    begin
      sh_d      = {sh_q[14:0], chain_q};
      bit_cnt_d = sat_inc(bit_cnt_q);
    end
    if (slave_fall)
    begin
      // Chaining only outside a conversion, so read-after only
      chain_d = (st_q == ST_IDLE) ? sync2_q.rdc : 1'b0;
    end

    case (st_q)
      ST_IDLE:
      begin
        if (conv_start)
        begin
          st_d       = ST_CONV;
          conv_cnt_d = '0;
          if (serial_en && master && rdc_mode)
          begin
            // Previous word goes out while this conversion runs
            sh_d      = result_q;
            bit_cnt_d = '0;
            mrun_d    = 1'b1;
            mclk_d    = 1'b0;
            mdiv_d    = '0;
          end
        end
      end
      ST_CONV:
      begin
        conv_cnt_d = conv_cnt_q + 1'b1;
        if (conv_done)
        begin
          result_d = conv_result_i;
          if (serial_en && partial_read(bit_cnt_q))
          begin
            rderr_d = 1'b1;
          end
          if (serial_en && master && !rdc_mode)
          begin
            st_d      = ST_POST;
            sh_d      = conv_result_i;
            bit_cnt_d = '0;
            mrun_d    = 1'b1;
            mclk_d    = 1'b0;
            mdiv_d    = '0;
          end
          else
          begin
            st_d = ST_IDLE;
            if (!master)
            begin
              // New word waits for the host after busy falls
              sh_d      = conv_result_i;
              bit_cnt_d = '0;
              chain_d   = 1'b0;
            end
          end
        end
      end
      ST_POST:
      begin
        if (!mrun_q)
        begin
          st_d = ST_IDLE;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q        <= ST_IDLE;
      conv_cnt_q  <= '0;
      result_q    <= '0;
      sh_q        <= '0;
      bit_cnt_q   <= '0;
      chain_q     <= 1'b0;
      mrun_q      <= 1'b0;
      mclk_q      <= 1'b0;
      mdiv_q      <= '0;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      conv_cnt_q  <= conv_cnt_d;
      result_q    <= result_d;
      sh_q        <= sh_d;
      bit_cnt_q   <= bit_cnt_d;
      chain_q     <= chain_d;
      mrun_q      <= mrun_d;
      mclk_q      <= mclk_d;
      mdiv_q      <= mdiv_d;
      sclk_prev_q <= sync2_q.sclk;
    end
  end

  // ****************************************************************
  // Output register
  // ****************************************************************
  asr_pin_out_t pins_q;
  asr_pin_out_t pins_d;

  always_comb
  begin
    pins_d.sdo     = sh_q[15];
    pins_d.sdo_oe  = serial_en && selected;
    // Clock pin leads the data pin by a cycle, so data moves after the fall
    pins_d.sclk    = mclk_d ^ sync2_q.inv;
    pins_d.sclk_oe = serial_en && selected && master;
    pins_d.sync    = mrun_q ^ sync2_q.inv;
    pins_d.sync_oe = serial_en && selected && master;
    pins_d.busy    = (st_q != ST_IDLE);
    pins_d.rderr   = rderr_d;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pins_q <= asr_pin_out_t'(`ASR_PIN_OUT_RST);
    end
    else
    begin
      pins_q <= pins_d;
    end
  end

  // Outputs come straight from the output register
  assign serial_result_out_o    = pins_q.sdo;
  assign serial_result_oe_o     = pins_q.sdo_oe;
  assign shift_clock_o          = pins_q.sclk;
  assign shift_clock_oe_o       = pins_q.sclk_oe;
  assign word_frame_o           = pins_q.sync;
  assign word_frame_oe_o        = pins_q.sync_oe;
  assign busy_o                 = pins_q.busy;
  assign incomplete_read_flag_o = pins_q.rderr;

endmodule
